/* File: verilog/fwd_map.svh */
`ifndef FWD_MAP_SVH
`define FWD_MAP_SVH

// Register byte offsets
`define FWD_OFS_CMD 12'h000
`define FWD_OFS_DIV 12'h004
`define FWD_OFS_RLD 12'h008
`define FWD_OFS_STAT 12'h00c

// Command keys
`define FWD_KEY_UNLOCK 16'h5555
`define FWD_KEY_RELOAD 16'haaaa
`define FWD_KEY_START 16'hcccc

// Reset values and the in-flight read marker
`define FWD_DIV_RST 3'h0
`define FWD_RLD_RST 12'hfff
`define FWD_READ_INVALID 32'hffff_ffff

// Status fields
`define FWD_STAT_DIV_BIT 0
`define FWD_STAT_RLD_BIT 1

// Divider decode: code 0 is divide by 4, codes at or above 6 are 256
`define FWD_DIV_BASE_SHIFT 4'h2
`define FWD_DIV_SAT_CODE 3'h6
`define FWD_DIV_SAT_SHIFT 4'h8

// Timing
`define FWD_CLK_PERIOD_NS 25
`define FWD_OSC_PERIOD_NS 25000
`define FWD_OSC_DIV (`FWD_OSC_PERIOD_NS / `FWD_CLK_PERIOD_NS)
`define FWD_SYNC_TICKS 3

`endif

/* File: verilog/fwd_pkg.sv */
package fwd_pkg;
  typedef logic [2:0] fwd_divcode_t;
  typedef logic [11:0] fwd_count_t;
  typedef enum logic [2:0] {
    FWD_CMD_NONE,
    FWD_CMD_UNLOCK,
    FWD_CMD_RELOAD,
    FWD_CMD_START,
    FWD_CMD_OTHER
  } fwd_cmd_e;
endpackage

/* File: verilog/fwd_xfer.sv */
`timescale 1ns/1ps
`include "fwd_map.svh"
module fwd_xfer #(
  parameter int W = 12,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter int SYNC_TICKS = `FWD_SYNC_TICKS,
  parameter int OSC_DIV = `FWD_OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic osc_tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic pending,
  output logic [W-1:0] value
);
  import fwd_pkg::*;
  localparam int TW = $clog2(SYNC_TICKS + 1);
  localparam int LIMIT = (SYNC_TICKS + 1) * OSC_DIV + 2;
  logic [W-1:0] stage, next_stage, next_value;
  logic next_pending;
  logic [TW-1:0] tk, next_tk;

  // A new write wins over a commit in the same cycle
  always_comb begin
    next_stage = stage;
    next_value = value;
    next_pending = pending;
    next_tk = tk;
    if (load) begin
      next_stage = load_val;
      next_pending = 1'b1;
      next_tk = '0;
    end else if (pending && osc_tick) begin
      if (tk == TW'(SYNC_TICKS - 1)) begin // R18
        next_value = stage; // R4 R11
        next_pending = 1'b0; // R4 R11
      end else begin
        next_tk = tk + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage <= RST_VAL;
      value <= RST_VAL;
      pending <= 1'b0;
      tk <= '0;
    end else begin
      stage <= next_stage;
      value <= next_value;
      pending <= next_pending;
      tk <= next_tk;
    end
  end

  // Helper: cycles spent pending since the last load
  int pend_cycles;
  always_ff @(posedge clk_sys) begin
    if (rst || load || !pending) pend_cycles <= 0;
    else pend_cycles <= pend_cycles + 1;
  end

  a_pending_bounded: assert property ( // R4 R11
    @(posedge clk_sys) disable iff (rst) pend_cycles <= LIMIT)
    else $error("update flag held too long");

  a_commit_value: assert property ( // R3 R10
    @(posedge clk_sys) disable iff (rst)
    (pending && !next_pending && !load) |=> (value == $past(stage)))
    else $error("committed value differs from written value");
endmodule

/* File: verilog/fwd_countdown.sv */
`timescale 1ns/1ps
`include "fwd_map.svh"
module fwd_countdown #(
  parameter int CW = 12,
  parameter int PW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic osc_tick,
  input wire fwd_pkg::fwd_divcode_t divider_code,
  input wire logic [CW-1:0] reload_count,
  input wire logic start,
  input wire logic reload,
  output logic running,
  output logic expired,
  output logic [CW-1:0] count
);
  import fwd_pkg::*;
  logic [PW-1:0] pre, next_pre, div_last;
  logic [PW:0] span;
  logic [3:0] shift;
  logic [CW-1:0] next_count;
  logic next_running, next_expired;
  logic start_p, next_start_p, rel_p, next_rel_p;

  // Eight-stage divider: 4 << code, saturating at 256
  always_comb begin
    if (divider_code >= `FWD_DIV_SAT_CODE) shift = `FWD_DIV_SAT_SHIFT; // R1
    else shift = 4'(divider_code) + `FWD_DIV_BASE_SHIFT; // R1
    span = (PW+1)'(1) << shift;
    div_last = PW'(span - (PW+1)'(1)); // R14
  end

  // Commands wait for the next oscillator tick; a new one is never lost
  always_comb begin
    next_pre = pre;
    next_count = count;
    next_running = running;
    next_start_p = start_p | start;
    next_rel_p = rel_p | reload;
    next_expired = expired | (running && count == '0 && !rel_p); // R15
    if (osc_tick) begin
      next_start_p = start;
      next_rel_p = reload;
      if (start_p) next_running = 1'b1; // R16
      if (rel_p) begin
        next_count = reload_count; // R8
        next_pre = '0;
      end else if (running && count != '0) begin
        if (pre == div_last) begin
          next_pre = '0;
          next_count = count - 1'b1; // R14
        end else begin
          next_pre = pre + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre <= '0;
      count <= `FWD_RLD_RST;
      running <= 1'b0;
      expired <= 1'b0;
      start_p <= 1'b0;
      rel_p <= 1'b0;
    end else begin
      pre <= next_pre;
      count <= next_count;
      running <= next_running;
      expired <= next_expired;
      start_p <= next_start_p;
      rel_p <= next_rel_p;
    end
  end

  a_zero_resets: assert property ( // R15
    @(posedge clk_sys) disable iff (rst)
    (running && count == '0 && !rel_p) |=> expired)
    else $error("no reset request at zero");

  a_reload_loads: assert property ( // R8
    @(posedge clk_sys) disable iff (rst)
    (rel_p && osc_tick) |=> (count == $past(reload_count)))
    else $error("reload did not load counter");

  a_start_runs: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    (start_p && osc_tick) |=> running)
    else $error("start did not run counter");

  a_div_saturate: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    (divider_code >= 3'h6) |-> (div_last == PW'(255)))
    else $error("divider codes 6 and 7 not divide by 256");

  a_div_min: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    (divider_code == 3'h0) |-> (div_last == PW'(3)))
    else $error("divider code 0 not divide by 4");
endmodule

/* File: verilog/fwd_top.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "fwd_map.svh"
// Contract
// [R1] Codes 0-5 divide 4..128, 6 and 7 divide 256
// [R2] Divider writes need prior unlock key
// [R3] Divider update flag set during transfer, read invalid
// [R4] Divider update flag clears after transfer
// [R5] Software waits flag clear before new divider
// [R6] Software waits both flags before low power
// [R7] Reload value 12 bits, resets all ones
// [R8] Reload key loads counter from reload value
// [R9] Reload writes need prior unlock key
// [R10] Reload update flag set during transfer, read invalid
// [R11] Reload update flag clears after transfer
// [R12] Software waits flag clear before new reload
// [R13] Half-word and word access; status flags bits 0,1
// [R14] Eight-stage divider feeds 12-bit down-counter
// [R15] Zero while running raises reset request
// [R16] Start key starts counting down
// [R17] Any other key restores write protection
// [R18] Flags clear after fixed oscillator tick count
module fwd_top #(
  parameter int OSC_DIV = `FWD_OSC_DIV,
  parameter int SYNC_TICKS = `FWD_SYNC_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdg_reset_request,
  output logic wdg_running
);
  import fwd_pkg::*;
  localparam int DW = $clog2(OSC_DIV + 1);

  fwd_cmd_e cmd;
  logic unlocked, next_unlocked;
  logic [DW-1:0] osc_cnt, next_osc_cnt;
  logic osc_tick, next_osc_tick;
  logic [31:0] next_prdata, rd_val;
  logic next_pready, next_pslverr;
  logic access, wr_lo, mapped;
  logic cmd_wr, div_load, rld_load, start_pulse, reload_pulse;
  logic div_pending, rld_pending;
  fwd_divcode_t divider_code;
  fwd_count_t reload_count;

  // Oscillator stand-in: one-cycle enable every OSC_DIV system clocks
  always_comb begin
    next_osc_tick = 1'b0;
    next_osc_cnt = osc_cnt + 1'b1;
    if (osc_cnt == DW'(OSC_DIV - 1)) begin
      next_osc_cnt = '0;
      next_osc_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_cnt <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_tick <= next_osc_tick;
    end
  end

  // A tick longer than one cycle would run the counter too fast
  a_tick_pulse: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    (osc_tick && OSC_DIV > 1) |=> !osc_tick)
    else $error("oscillator enable held for two cycles");

  // Bus decode; a write lands only at the edge that completes the access
  always_comb begin
    access = psel && penable && pready;
    // Upper half-word alone touches only reserved bits and is dropped
    wr_lo = access && pwrite && (pstrb[1:0] == 2'b11); // R13
    mapped = (paddr == `FWD_OFS_CMD) || (paddr == `FWD_OFS_DIV) ||
             (paddr == `FWD_OFS_RLD) || (paddr == `FWD_OFS_STAT);
    cmd_wr = wr_lo && (paddr == `FWD_OFS_CMD);
    div_load = wr_lo && (paddr == `FWD_OFS_DIV) && unlocked; // R2
    rld_load = wr_lo && (paddr == `FWD_OFS_RLD) && unlocked; // R9
  end

  // Command key decode
  always_comb begin
    case (pwdata[15:0])
      `FWD_KEY_UNLOCK: cmd = FWD_CMD_UNLOCK;
      `FWD_KEY_RELOAD: cmd = FWD_CMD_RELOAD;
      `FWD_KEY_START: cmd = FWD_CMD_START;
      default: cmd = FWD_CMD_OTHER;
    endcase
    if (!cmd_wr) cmd = FWD_CMD_NONE;
  end

  // Write protection and command pulses
  always_comb begin
    next_unlocked = unlocked;
    start_pulse = 1'b0;
    reload_pulse = 1'b0;
    case (cmd)
      FWD_CMD_NONE: next_unlocked = unlocked;
      FWD_CMD_UNLOCK: next_unlocked = 1'b1; // R2 R9
      FWD_CMD_RELOAD: begin
        next_unlocked = 1'b0; // R17
        reload_pulse = 1'b1; // R8
      end
      FWD_CMD_START: begin
        next_unlocked = 1'b0; // R17
        start_pulse = 1'b1; // R16
      end
      default: next_unlocked = 1'b0; // R17
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) unlocked <= 1'b0;
    else unlocked <= next_unlocked;
  end

  // Only a command write may open or close the protection
  a_unlock_key: assert property ( // R2 R9
    @(posedge clk_sys) disable iff (rst)
    (cmd_wr && pwdata[15:0] == `FWD_KEY_UNLOCK) |=> unlocked)
    else $error("unlock key did not open protection");

  a_lock_steady: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    !cmd_wr |=> (unlocked == $past(unlocked)))
    else $error("protection changed without a command");

  // Divider and reload values cross to the tick domain in two independent transfers that may overlap
  fwd_xfer #(
    .W(3),
    .RST_VAL(`FWD_DIV_RST),
    .SYNC_TICKS(SYNC_TICKS),
    .OSC_DIV(OSC_DIV)
  ) u_div_xfer (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_tick(osc_tick),
    .load(div_load), // R3
    .load_val(pwdata[2:0]),
    .pending(div_pending),
    .value(divider_code)
  );

  fwd_xfer #(
    .W(12),
    .RST_VAL(`FWD_RLD_RST), // R7
    .SYNC_TICKS(SYNC_TICKS),
    .OSC_DIV(OSC_DIV)
  ) u_rld_xfer (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_tick(osc_tick),
    .load(rld_load), // R10
    .load_val(pwdata[11:0]),
    .pending(rld_pending),
    .value(reload_count)
  );

  fwd_countdown #(
    .CW(12),
    .PW(8)
  ) u_count (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_tick(osc_tick),
    .divider_code(divider_code),
    .reload_count(reload_count),
    .start(start_pulse),
    .reload(reload_pulse),
    .running(wdg_running),
    .expired(wdg_reset_request),
    .count()
  );

  // Read mux; in-flight values read as a marker, never a half-moved value
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr == `FWD_OFS_DIV) begin
      rd_val = div_pending ? `FWD_READ_INVALID : {29'h0, divider_code}; // R3
    end else if (paddr == `FWD_OFS_RLD) begin
      rd_val = rld_pending ? `FWD_READ_INVALID : {20'h0, reload_count}; // R10
    end else if (paddr == `FWD_OFS_STAT) begin
      rd_val[`FWD_STAT_DIV_BIT] = div_pending; // R13
      rd_val[`FWD_STAT_RLD_BIT] = rld_pending; // R13
    end
  end

  // A value still in flight must never be read back as settled
  a_div_read_invalid: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    (psel && penable && !pready && !pwrite && paddr == `FWD_OFS_DIV && div_pending)
      |=> (prdata == `FWD_READ_INVALID))
    else $error("divider read while pending not invalid");

  a_rld_read_invalid: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    (psel && penable && !pready && !pwrite && paddr == `FWD_OFS_RLD && rld_pending)
      |=> (prdata == `FWD_READ_INVALID))
    else $error("reload read while pending not invalid");

  // One wait state so that every bus output leaves a flip-flop
  always_comb begin
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_pslverr = !mapped;
      next_prdata = (!pwrite && mapped) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Bus answers: one-cycle ready, error only for holes in the map
  a_ready_pulse: assert property (
    @(posedge clk_sys) disable iff (rst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_unmapped: assert property (
    @(posedge clk_sys) disable iff (rst)
    (psel && penable && !pready) |=> (pslverr == !$past(mapped)))
    else $error("error response does not match address map");

  a_write_reads_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    (psel && penable && !pready && pwrite) |=> (prdata == 32'h0000_0000))
    else $error("write answer carried read data");

  a_locked_div: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    (wr_lo && paddr == `FWD_OFS_DIV && !unlocked && !div_pending) |=> !div_pending)
    else $error("divider write accepted while locked");

  a_locked_rld: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    (wr_lo && paddr == `FWD_OFS_RLD && !unlocked && !rld_pending) |=> !rld_pending)
    else $error("reload write accepted while locked");

  a_relock_other: assert property ( // R17
    @(posedge clk_sys) disable iff (rst)
    (cmd_wr && pwdata[15:0] != `FWD_KEY_UNLOCK) |=> !unlocked)
    else $error("protection not restored");

  a_div_flag_set: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    (wr_lo && paddr == `FWD_OFS_DIV && unlocked) |=> div_pending [*2])
    else $error("divider flag not set on write");

  a_rld_flag_set: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    (wr_lo && paddr == `FWD_OFS_RLD && unlocked) |=> rld_pending [*2])
    else $error("reload flag not set on write");

  a_status_read: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    (pready && !pwrite && paddr == `FWD_OFS_STAT) |->
      (prdata == {30'h0, $past(rld_pending), $past(div_pending)}))
    else $error("status read wrong");

  a_rld_reset: assert property ( // R7
    @(posedge clk_sys) $fell(rst) |-> (reload_count == 12'hfff))
    else $error("reload value not all ones after reset");

  a_apb_answer: assert property (
    @(posedge clk_sys) disable iff (rst)
    (psel && penable && !pready) |=> pready)
    else $error("access phase not answered");

  // Start and reset request are one-way until the next reset
  a_running_sticky: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    wdg_running |=> wdg_running)
    else $error("counter stopped without a reset");

  a_request_sticky: assert property ( // R15
    @(posedge clk_sys) disable iff (rst)
    wdg_reset_request |=> wdg_reset_request)
    else $error("reset request dropped without a reset");

  a_request_needs_run: assert property ( // R15
    @(posedge clk_sys) disable iff (rst)
    $rose(wdg_reset_request) |-> $past(wdg_running))
    else $error("reset request raised while stopped");
endmodule

/* File: testbench/fwd_tb_top.sv */
`timescale 1ns/1ps
`include "fwd_map.svh"

// Compare, count, report at once; four-state compare so an unknown never matches
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module fwd_tb_top;
  import fwd_pkg::*;
  // Short oscillator tick and sync depth keep the run brief
  localparam int OSC = 4;
  localparam int SYN = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdg_reset_request;
  logic wdg_running;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int dv;
  int n;

  // Bus clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  fwd_top #(.OSC_DIV(OSC), .SYNC_TICKS(SYN)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wdg_reset_request(wdg_reset_request),
    .wdg_running(wdg_running)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard: longest expiry needs about 2100 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  // One transfer; idle edge first so back-to-back calls never drive twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One wait state: ready is seen at the second edge of the access phase
    `CHK("pready wait", 2, k)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK(nm, e, rd)
  endtask

  // Poll status until both flags drop; bounded since transfer is a few ticks
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `FWD_OFS_STAT, 32'h0000_0000, 4'h0);
      k++;
    end while (rd !== 32'h0000_0000 && k < 8);
    `CHK("status idle", 32'h0000_0000, rd)
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // Main sequence
  initial begin
    do_reset();
    rchk("div reset", `FWD_OFS_DIV, 32'h0000_0000);
    rchk("rld reset", `FWD_OFS_RLD, 32'h0000_0fff);
    rchk("stat reset", `FWD_OFS_STAT, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000, 4'h0);
    `CHK("unmapped err", 1'b1, err)
    $display("test reset_map done");
    // Writes before unlocking must not land
    wr(`FWD_OFS_DIV, 32'h0000_0005);
    wr(`FWD_OFS_RLD, 32'h0000_0123);
    rchk("div locked", `FWD_OFS_DIV, 32'h0000_0000);
    rchk("rld locked", `FWD_OFS_RLD, 32'h0000_0fff);
    $display("test locked done");
    // One read per write while pending: the flag may drop after five cycles
    wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_UNLOCK});
    apb(1'b1, `FWD_OFS_RLD, 32'h0000_0123, 4'h3);
    rchk("rld invalid", `FWD_OFS_RLD, 32'hffff_ffff);
    wait_idle();
    rchk("rld new", `FWD_OFS_RLD, 32'h0000_0123);
    wr(`FWD_OFS_DIV, 32'h0000_0003);
    rchk("div invalid", `FWD_OFS_DIV, 32'hffff_ffff);
    wait_idle();
    rchk("div new", `FWD_OFS_DIV, 32'h0000_0003);
    wr(`FWD_OFS_RLD, 32'h0000_0456);
    rchk("rld flag", `FWD_OFS_STAT, 32'h0000_0002);
    wait_idle();
    wr(`FWD_OFS_DIV, 32'h0000_0005);
    rchk("div flag", `FWD_OFS_STAT, 32'h0000_0001);
    wait_idle();
    // Upper half-word alone carries no field and must not start a transfer
    apb(1'b1, `FWD_OFS_DIV, 32'h0000_0002, 4'hc);
    rchk("div upper only", `FWD_OFS_DIV, 32'h0000_0005);
    `CHK("mapped no err", 1'b0, err)
    $display("test transfer done");
    // Any other key relocks, the reload key included
    wr(`FWD_OFS_CMD, 32'h0000_1234);
    wr(`FWD_OFS_DIV, 32'h0000_0001);
    rchk("div relocked", `FWD_OFS_DIV, 32'h0000_0005);
    wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_UNLOCK});
    wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_RELOAD});
    wr(`FWD_OFS_RLD, 32'h0000_0007);
    rchk("rld relocked", `FWD_OFS_RLD, 32'h0000_0456);
    wr(`FWD_OFS_STAT, 32'h0000_0003);
    rchk("stat read only", `FWD_OFS_STAT, 32'h0000_0000);
    $display("test relock done");
    // Expiry per code; reload after start so the prescaler phase is known
    for (int c = 0; c < 8; c++) begin
      do_reset();
      `CHK("running after reset", 1'b0, wdg_running)
      wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_UNLOCK});
      wr(`FWD_OFS_DIV, 32'(c));
      wr(`FWD_OFS_RLD, 32'h0000_0002);
      wait_idle();
      wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_START});
      wr(`FWD_OFS_CMD, {16'h0000, `FWD_KEY_RELOAD});
      dv = (c >= 6) ? 256 : (4 << c);
      n = 0;
      while (wdg_reset_request !== 1'b1 && n < (2 * dv + 1) * OSC + 4) begin
        @(posedge clk_sys);
        n++;
      end
      `CHK("expiry not early", 1'b1, n >= (2 * dv - 1) * OSC)
      `CHK("expiry raised", 1'b1, wdg_reset_request)
      `CHK("running", 1'b1, wdg_running)
    end
    $display("test expiry done");
    stop_test();
  end
endmodule
